// ===== core/opcode_map_decoder.v
// Registered opcode decoder stage with prefix tracking and index advance
`timescale 1ns/1ns

// Overview of operation
// - Row 0: bit test-and-branch, 3 bytes, 5 cycles
// - Row 1: bit set/clear, 2 bytes, 4 cycles
// - Row 9 low 0,1,3: signed branches, 2/3
// - Columns A-D pick immediate/direct/extended/16-bit indexed
// - Low nibble selects register/memory operation
// - A7 is stack add immediate, not store
// - Compare-branch-equal variants with their lengths, cycles
// - 71 post-increment compare-branch; 81 subroutine return
// - Post-increment modes advance index after operand
module opcode_map_decoder (
    sys_clk,
    reset_n,
    fetch_valid,
    fetch_byte,
    operand_fetched,
    index_in,
    dec_valid,
    dec_op,
    dec_mode,
    dec_len,
    dec_cycles,
    dec_bit_index,
    dec_postinc,
    dec_illegal,
    prefix_pending,
    index_update,
    index_next
);
`include "opcode_map_defs.vh"
    input wire sys_clk; // Processor bus clock, 25 MHz
    input wire reset_n; // Synchronous reset, active low
    input wire fetch_valid; // Fetch unit presents an opcode byte
    input wire [7:0] fetch_byte; // Fetched opcode or prefix byte
    input wire operand_fetched; // Execution stage finished operand fetch
    input wire [15:0] index_in; // Current index register value
    output reg dec_valid; // High the cycle after each opcode byte, so it stays high over back-to-back bytes: decode fields valid
    output reg [5:0] dec_op; // Operation
    output reg [3:0] dec_mode; // Addressing mode
    output reg [2:0] dec_len; // Instruction bytes
    output reg [3:0] dec_cycles; // Execution cycles
    output reg [2:0] dec_bit_index; // Bit number
    output reg dec_postinc; // Post-increment instruction
    output reg dec_illegal; // Opcode not covered here
    output wire prefix_pending; // Prefix seen, awaiting next byte
    output reg index_update; // Pulse: load index_next into index
    output reg [15:0] index_next; // Advanced index value

    reg prefix_q; // Prefix byte has been taken
    reg prefix_d;
    reg postinc_q; // Current instruction advances index
    reg postinc_d;
    wire is_prefix; // Incoming byte is the prefix
    wire [5:0] lk_op;
    wire [3:0] lk_mode;
    wire [2:0] lk_len;
    wire [3:0] lk_cycles;
    wire [2:0] lk_bit;
    wire lk_postinc;
    wire lk_legal;

    // A second prefix in a row is treated as an ordinary opcode, not chained
    assign is_prefix = fetch_valid && !prefix_q && (fetch_byte == `PREFIX_SP);
    assign prefix_pending = prefix_q;

    // Table lookup for the byte following any prefix
    opcode_row_lookup u_lookup (
        .opcode(fetch_byte),
        .sp_prefix(prefix_q),
        .op(lk_op),
        .mode(lk_mode),
        .len(lk_len),
        .cycles(lk_cycles),
        .bit_index(lk_bit),
        .postinc(lk_postinc),
        .legal(lk_legal)
    );

    // Next-state for prefix and post-increment tracking
    always @* begin
        prefix_d = prefix_q;
        postinc_d = postinc_q;
        if (fetch_valid) begin
            // Prefix arms the stack-relative decode of the next byte
            prefix_d = is_prefix;
            if (!is_prefix) begin
                postinc_d = lk_postinc && lk_legal;
            end
        end else if (operand_fetched) begin
            // Advance happens once, then clears
            postinc_d = 1'b0;
        end
    end

    // Decode output register
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            prefix_q <= 1'b0;
            postinc_q <= 1'b0;
            dec_valid <= 1'b0;
            dec_op <= `RST_OP;
            dec_mode <= `RST_MODE;
            dec_len <= `RST_LEN;
            dec_cycles <= `RST_CYC;
            dec_bit_index <= 3'h0;
            dec_postinc <= 1'b0;
            dec_illegal <= 1'b0;
        end else begin
            prefix_q <= prefix_d;
            postinc_q <= postinc_d;
            // Pulse only on a real opcode byte, never on the prefix itself
            dec_valid <= fetch_valid && !is_prefix;
            if (fetch_valid && !is_prefix) begin
                dec_op <= lk_op;
                dec_mode <= lk_mode;
                dec_len <= lk_len;
                dec_cycles <= lk_cycles;
                dec_bit_index <= lk_bit;
                dec_postinc <= lk_postinc;
                dec_illegal <= !lk_legal;
            end
        end
    end

    // Index advance after operand fetch of post-increment forms
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            index_update <= 1'b0;
            index_next <= 16'h0000;
        end else begin
            // Next access uses the following address
            index_update <= operand_fetched && postinc_q && !fetch_valid;
            if (operand_fetched && postinc_q && !fetch_valid) begin
                index_next <= index_in + 16'h0001;
            end
        end
    end
endmodule

// ===== core/opcode_map_defs.vh
// Constants for the opcode map decoder: operations, modes, lengths, cycle counts
`ifndef OPCODE_MAP_DEFS_VH
`define OPCODE_MAP_DEFS_VH

// Prefix byte that selects stack-pointer-relative forms
`define PREFIX_SP 8'h9e

// Operation codes (6 bits)
`define OP_ILLEGAL 6'h00
`define OP_BRANCH_IF_BIT_SET 6'h01
`define OP_BRANCH_IF_BIT_CLEAR 6'h02
`define OP_SET_MEMORY_BIT 6'h03
`define OP_CLEAR_MEMORY_BIT 6'h04
`define OP_BRANCH_SIGNED_GE 6'h05
`define OP_BRANCH_SIGNED_LT 6'h06
`define OP_BRANCH_SIGNED_LE 6'h07
`define OP_SUBTRACT 6'h08
`define OP_COMPARE_ACCUMULATOR 6'h09
`define OP_SUBTRACT_WITH_CARRY 6'h0a
`define OP_COMPARE_INDEX_LOW 6'h0b
`define OP_LOGICAL_AND 6'h0c
`define OP_BIT_TEST 6'h0d
`define OP_LOAD_ACCUMULATOR 6'h0e
`define OP_STORE_ACCUMULATOR 6'h0f
`define OP_ADD_IMMEDIATE_STACK_POINTER 6'h10
`define OP_COMPARE_BRANCH_EQUAL 6'h11
`define OP_COMPARE_BRANCH_EQUAL_ACC_IMM 6'h12
`define OP_COMPARE_BRANCH_EQUAL_INDEX_IMM 6'h13
`define OP_SUBROUTINE_RETURN 6'h14

// Addressing modes (4 bits)
`define MODE_NONE 4'h0
`define MODE_DIRECT 4'h1
`define MODE_RELATIVE 4'h2
`define MODE_IMMEDIATE 4'h3
`define MODE_EXTENDED 4'h4
`define MODE_INDEXED_16BIT_OFFSET 4'h5
`define MODE_INDEXED_8BIT_OFFSET 4'h6
`define MODE_INDEXED 4'h7
`define MODE_STACK_8BIT_OFFSET 4'h8
`define MODE_STACK_16BIT_OFFSET 4'h9
`define MODE_INDEXED_8BIT_OFFSET_POSTINC 4'ha
`define MODE_INDEXED_POSTINC 4'hb
`define MODE_INHERENT 4'hc

// Lengths in bytes (3 bits) and cycle counts (4 bits)
`define LEN_1 3'h1
`define LEN_2 3'h2
`define LEN_3 3'h3
`define LEN_4 3'h4
`define CYC_2 4'h2
`define CYC_3 4'h3
`define CYC_4 4'h4
`define CYC_5 4'h5
`define CYC_6 4'h6

// Reset values of the decoded outputs
`define RST_OP 6'h00
`define RST_MODE 4'h0
`define RST_LEN 3'h0
`define RST_CYC 4'h0

`endif

// ===== core/opcode_row_lookup.v
// Combinational lookup of one opcode (low nibble 0..7) into its control fields
`timescale 1ns/1ns

module opcode_row_lookup (
    opcode,
    sp_prefix,
    op,
    mode,
    len,
    cycles,
    bit_index,
    postinc,
    legal
);
`include "opcode_map_defs.vh"
    input wire [7:0] opcode; // Opcode byte after any prefix
    input wire sp_prefix; // Prefix byte preceded this opcode
    output reg [5:0] op; // Decoded operation
    output reg [3:0] mode; // Decoded addressing mode
    output reg [2:0] len; // Bytes including prefix
    output reg [3:0] cycles; // Cycles including prefix
    output reg [2:0] bit_index; // Bit number for bit operations
    output reg postinc; // Index advances after operand fetch
    output reg legal; // Opcode is covered by this decoder

    wire [3:0] hi = opcode[7:4]; // Row selector column
    wire [3:0] lo = opcode[3:0]; // Operation selector

    // Main decode table
    always @* begin
        op = `OP_ILLEGAL;
        mode = `MODE_NONE;
        len = `RST_LEN;
        cycles = `RST_CYC;
        bit_index = lo[3:1];
        postinc = 1'b0;
        legal = 1'b0;
        if (lo[3] == 1'b0) begin
            if (!sp_prefix) begin
                case (hi)
                    4'h0: begin
                        // Test-bit-and-branch
                        op = lo[0] ? `OP_BRANCH_IF_BIT_CLEAR : `OP_BRANCH_IF_BIT_SET;
                        mode = `MODE_DIRECT;
                        len = `LEN_3;
                        cycles = `CYC_5;
                        legal = 1'b1;
                    end
                    4'h1: begin
                        // Single-bit write
                        op = lo[0] ? `OP_CLEAR_MEMORY_BIT : `OP_SET_MEMORY_BIT;
                        mode = `MODE_DIRECT;
                        len = `LEN_2;
                        cycles = `CYC_4;
                        legal = 1'b1;
                    end
                    4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
                        if (lo == 4'h1) begin
                            legal = 1'b1;
                            case (hi)
                                4'h3: begin
                                    // Direct compare-and-branch
                                    op = `OP_COMPARE_BRANCH_EQUAL;
                                    mode = `MODE_DIRECT;
                                    len = `LEN_3;
                                    cycles = `CYC_5;
                                end
                                4'h4: begin
                                    // Accumulator against immediate
                                    op = `OP_COMPARE_BRANCH_EQUAL_ACC_IMM;
                                    mode = `MODE_IMMEDIATE;
                                    len = `LEN_3;
                                    cycles = `CYC_4;
                                end
                                4'h5: begin
                                    // Index against immediate
                                    op = `OP_COMPARE_BRANCH_EQUAL_INDEX_IMM;
                                    mode = `MODE_IMMEDIATE;
                                    len = `LEN_3;
                                    cycles = `CYC_4;
                                end
                                4'h6: begin
                                    // Offset with post-increment
                                    op = `OP_COMPARE_BRANCH_EQUAL;
                                    mode = `MODE_INDEXED_8BIT_OFFSET_POSTINC;
                                    len = `LEN_3;
                                    cycles = `CYC_5;
                                    postinc = 1'b1;
                                end
                                default: begin
                                    // No-offset post-increment form
                                    op = `OP_COMPARE_BRANCH_EQUAL;
                                    mode = `MODE_INDEXED_POSTINC;
                                    len = `LEN_2;
                                    cycles = `CYC_4;
                                    postinc = 1'b1;
                                end
                            endcase
                        end
                    end
                    4'h8: begin
                        if (lo == 4'h1) begin
                            // Subroutine return
                            op = `OP_SUBROUTINE_RETURN;
                            mode = `MODE_INHERENT;
                            len = `LEN_1;
                            cycles = `CYC_4;
                            legal = 1'b1;
                        end
                    end
                    4'h9: begin
                        // Signed relative branches
                        legal = (lo == 4'h0) || (lo == 4'h1) || (lo == 4'h3);
                        op = (lo == 4'h0) ? `OP_BRANCH_SIGNED_GE :
                             (lo == 4'h1) ? `OP_BRANCH_SIGNED_LT :
                             (lo == 4'h3) ? `OP_BRANCH_SIGNED_LE : `OP_ILLEGAL;
                        mode = legal ? `MODE_RELATIVE : `MODE_NONE;
                        len = legal ? `LEN_2 : `RST_LEN;
                        cycles = legal ? `CYC_3 : `RST_CYC;
                    end
                    4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: begin
                        // Register/memory operation from low nibble
                        op = `OP_SUBTRACT + {3'h0, lo[2:0]};
                        legal = 1'b1;
                        case (hi)
                            4'ha: begin
                                // Immediate column
                                mode = `MODE_IMMEDIATE;
                                len = `LEN_2;
                                cycles = `CYC_2;
                                if (lo == 4'h7) begin
                                    // No immediate store; stack adjust instead
                                    op = `OP_ADD_IMMEDIATE_STACK_POINTER;
                                end
                            end
                            4'hb: begin
                                // Direct column
                                mode = `MODE_DIRECT;
                                len = `LEN_2;
                                cycles = `CYC_3;
                            end
                            4'hc: begin
                                // Extended column
                                mode = `MODE_EXTENDED;
                                len = `LEN_3;
                                cycles = `CYC_4;
                            end
                            4'hd: begin
                                // 16-bit indexed offset column
                                mode = `MODE_INDEXED_16BIT_OFFSET;
                                len = `LEN_3;
                                cycles = `CYC_4;
                            end
                            4'he: begin
                                // 8-bit indexed offset column
                                mode = `MODE_INDEXED_8BIT_OFFSET;
                                len = `LEN_2;
                                cycles = `CYC_3;
                            end
                            default: begin
                                // Indexed, no offset column
                                mode = `MODE_INDEXED;
                                len = `LEN_1;
                                cycles = `CYC_2;
                            end
                        endcase
                    end
                    default: begin
                        // Rows outside this decoder stay illegal
                        legal = 1'b0;
                    end
                endcase
            end else begin
                // Prefixed forms; lengths and cycles include the prefix
                case (hi)
                    4'h6: begin
                        if (lo == 4'h1) begin
                            // Stack compare-and-branch
                            op = `OP_COMPARE_BRANCH_EQUAL;
                            mode = `MODE_STACK_8BIT_OFFSET;
                            len = `LEN_4;
                            cycles = `CYC_6;
                            legal = 1'b1;
                        end
                    end
                    4'hd: begin
                        // Stack 16-bit offset register/memory
                        op = `OP_SUBTRACT + {3'h0, lo[2:0]};
                        mode = `MODE_STACK_16BIT_OFFSET;
                        len = `LEN_4;
                        cycles = `CYC_5;
                        legal = 1'b1;
                    end
                    4'he: begin
                        // Stack 8-bit offset register/memory
                        op = `OP_SUBTRACT + {3'h0, lo[2:0]};
                        mode = `MODE_STACK_8BIT_OFFSET;
                        len = `LEN_3;
                        cycles = `CYC_4;
                        legal = 1'b1;
                    end
                    default: begin
                        // No other prefixed forms here
                        legal = 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// ===== verification/fetch_exec_model.sv
// Fetch unit and execution datapath model facing the decoder
`timescale 1ns/1ns
module fetch_exec_model (
    input wire sys_clk,
    input wire index_update,
    input wire [15:0] index_next,
    output reg fetch_valid,
    output reg [7:0] fetch_byte,
    output reg operand_fetched,
    output reg [15:0] index_in
);
    // Nothing requested at time zero
    initial begin
        fetch_valid = 1'b0;
        fetch_byte = 8'h00;
        operand_fetched = 1'b0;
        index_in = 16'h0000;
    end
    // Index register takes the advanced value on the update pulse
    always @(posedge sys_clk) begin
        if (index_update === 1'b1) begin
            index_in <= index_next;
        end
    end
    // Byte for the next rising edge; valid stays up
    task send(input [7:0] b);
        begin
            fetch_valid = 1'b1;
            fetch_byte = b;
            @(negedge sys_clk);
        end
    endtask
    // Release fetch; the byte lines show junk so stale values never look valid
    task idle;
        begin
            fetch_valid = 1'b0;
            fetch_byte = ~fetch_byte;
            @(negedge sys_clk);
        end
    endtask
    // One-cycle operand-done pulse with the index value of that moment
    task operand_done(input [15:0] idx);
        begin
            operand_fetched = 1'b1;
            index_in = idx;
            @(negedge sys_clk);
            operand_fetched = 1'b0;
        end
    endtask
endmodule

// ===== verification/opcode_map_decoder_properties.sv
// Concurrent checks on the opcode decoder ports
`timescale 1ns/1ns
`include "opcode_map_defs.vh"
module opcode_map_decoder_properties (
    input wire sys_clk,
    input wire reset_n,
    input wire fetch_valid,
    input wire [7:0] fetch_byte,
    input wire operand_fetched,
    input wire [15:0] index_in,
    input wire dec_valid,
    input wire [5:0] dec_op,
    input wire [3:0] dec_mode,
    input wire [2:0] dec_len,
    input wire [3:0] dec_cycles,
    input wire [2:0] dec_bit_index,
    input wire dec_postinc,
    input wire dec_illegal,
    input wire prefix_pending,
    input wire index_update,
    input wire [15:0] index_next
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Byte taken with no prefix in front of it
    wire plain_take = fetch_valid && !prefix_pending;
    // Prefix byte accepted
    sequence s_prefix_take;
        plain_take && fetch_byte == `PREFIX_SP;
    endsequence
    // Prefix followed at once by a stack-form load
    sequence s_prefixed_load;
        s_prefix_take ##1 fetch_valid && fetch_byte == 8'he6;
    endsequence
    a_valid_follows_fetch: assert property (fetch_valid && !(plain_take &&
        fetch_byte == `PREFIX_SP) |=> dec_valid) else $error("no decode after fetch");
    a_prefix_holds_back: assert property (s_prefix_take |=> !dec_valid &&
        prefix_pending) else $error("prefix decoded as opcode");
    a_prefix_stack_form: assert property (s_prefixed_load |=>
        dec_mode == `MODE_STACK_8BIT_OFFSET && dec_len == `LEN_3 && dec_cycles == `CYC_4
        && !prefix_pending) else $error("prefixed load wrong");
    a_bit_branch_row: assert property (plain_take && fetch_byte[7:3] == 5'h00 |=>
        dec_len == `LEN_3 && dec_cycles == `CYC_5 && dec_mode == `MODE_DIRECT &&
        dec_bit_index == $past(fetch_byte[3:1]) && dec_op == ($past(fetch_byte[0]) ?
        `OP_BRANCH_IF_BIT_CLEAR : `OP_BRANCH_IF_BIT_SET)) else $error("bit branch wrong");
    a_bit_write_row: assert property (plain_take && fetch_byte[7:3] == 5'h02 |=>
        dec_len == `LEN_2 && dec_cycles == `CYC_4 && dec_mode == `MODE_DIRECT &&
        dec_bit_index == $past(fetch_byte[3:1]) && dec_op == ($past(fetch_byte[0]) ?
        `OP_CLEAR_MEMORY_BIT : `OP_SET_MEMORY_BIT)) else $error("bit write wrong");
    a_direct_operation: assert property (plain_take && fetch_byte[7:3] == 5'h16 |=>
        dec_op == `OP_SUBTRACT + {3'h0, $past(fetch_byte[2:0])} && dec_len == `LEN_2
        && dec_cycles == `CYC_3 && dec_mode == `MODE_DIRECT) else $error("direct op wrong");
    a_signed_branch: assert property (plain_take && fetch_byte == 8'h93 |=>
        dec_op == `OP_BRANCH_SIGNED_LE && dec_mode == `MODE_RELATIVE && dec_len == `LEN_2
        && dec_cycles == `CYC_3) else $error("signed branch wrong");
    a_stack_add: assert property (plain_take && fetch_byte == 8'ha7 |=>
        dec_op == `OP_ADD_IMMEDIATE_STACK_POINTER && dec_len == `LEN_2 &&
        dec_cycles == `CYC_2) else $error("stack add wrong");
    a_return_decode: assert property (plain_take && fetch_byte == 8'h81 |=>
        dec_op == `OP_SUBROUTINE_RETURN && dec_len == `LEN_1 && dec_cycles == `CYC_4)
        else $error("return decode wrong");
    a_index_advance: assert property (index_update |-> $past(operand_fetched) &&
        !$past(fetch_valid) && index_next == $past(index_in) + 16'h0001)
        else $error("index advance wrong");
    a_update_single: assert property (index_update |=> !index_update)
        else $error("index update not a pulse");
endmodule

bind opcode_map_decoder opcode_map_decoder_properties u_props (.sys_clk, .reset_n,
    .fetch_valid, .fetch_byte, .operand_fetched, .index_in, .dec_valid, .dec_op, .dec_mode,
    .dec_len, .dec_cycles, .dec_bit_index, .dec_postinc, .dec_illegal, .prefix_pending,
    .index_update, .index_next);

// ===== verification/testbench.sv
// Self-checking bench for the opcode map decoder
`timescale 1ns/1ns
`include "opcode_map_defs.vh"
module testbench;
    reg sys_clk = 1'b0; // 25 MHz bus clock
    reg reset_n = 1'b0; // Synchronous reset, active low
    wire fetch_valid, operand_fetched, dec_valid, dec_postinc, dec_illegal;
    wire prefix_pending, index_update;
    wire [7:0] fetch_byte;
    wire [15:0] index_in, index_next;
    wire [5:0] dec_op;
    wire [3:0] dec_mode, dec_cycles;
    wire [2:0] dec_len, dec_bit_index;
    // All decode fields in one word so one compare covers them
    wire [23:0] all_out = {dec_valid, dec_illegal, dec_op, dec_mode, dec_len, dec_cycles,
        dec_bit_index, dec_postinc, prefix_pending};
    integer n_fail = 0;
    integer n_checks = 0;
    integer cycles = 0; // Hang guard count
    integer i;
    // Mode, length, cycles per column, column A in the low slice
    wire [15:0] col_mode = {`MODE_INDEXED_16BIT_OFFSET, `MODE_EXTENDED, `MODE_DIRECT,
        `MODE_IMMEDIATE};
    wire [11:0] col_len = {`LEN_3, `LEN_3, `LEN_2, `LEN_2};
    wire [15:0] col_cyc = {`CYC_4, `CYC_4, `CYC_3, `CYC_2};

    // Clock: 40 ns period
    always #20 sys_clk = ~sys_clk;

    opcode_map_decoder u_dut (.sys_clk, .reset_n, .fetch_valid, .fetch_byte,
        .operand_fetched, .index_in, .dec_valid, .dec_op, .dec_mode, .dec_len, .dec_cycles,
        .dec_bit_index, .dec_postinc, .dec_illegal, .prefix_pending, .index_update,
        .index_next);
    fetch_exec_model u_partner (.sys_clk, .index_update, .index_next, .fetch_valid,
        .fetch_byte, .operand_fetched, .index_in);

    // Compare and count; four-state so unknowns fail
    task check(input [23:0] seen, input [23:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Decode one byte and compare valid, legality, op, mode, length and cycles
    task expect_dec(input [7:0] b, input [5:0] op, input [3:0] md, input [2:0] ln,
        input [3:0] cy);
        begin
            u_partner.send(b);
            check({5'h00, all_out[23:5]}, {5'h00, 1'b1, 1'b0, op, md, ln, cy});
        end
    endtask
    // Verdict and end of run
    task stop_test;
        begin
            $display("Checks %0d, mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Reset values, and a mid-run reset that drops a pending prefix
    task t_reset;
        begin
            check(all_out, 24'h000000);
            check({7'h00, index_update, index_next}, 24'h000000);
            u_partner.send(`PREFIX_SP);
            check({23'h0, prefix_pending}, 24'h000001);
            u_partner.idle;
            reset_n = 1'b0;
            @(negedge sys_clk);
            reset_n = 1'b1;
            check(all_out, 24'h000000);
            $display("t_reset done");
        end
    endtask
    // Rows 0 and 1, back to back, bit index from the low nibble
    task t_bit_rows;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                expect_dec(i[7:0], i[0] ? `OP_BRANCH_IF_BIT_CLEAR : `OP_BRANCH_IF_BIT_SET,
                    `MODE_DIRECT, `LEN_3, `CYC_5);
                check({21'h0, dec_bit_index}, {21'h0, i[3:1]});
                expect_dec(8'h10 + i[7:0], i[0] ? `OP_CLEAR_MEMORY_BIT : `OP_SET_MEMORY_BIT,
                    `MODE_DIRECT, `LEN_2, `CYC_4);
                check({21'h0, dec_bit_index}, {21'h0, i[3:1]});
            end
            u_partner.idle;
            $display("t_bit_rows done");
        end
    endtask
    // Columns A..D, low nibble 0..7; A7 is the stack add
    task t_rm_columns;
        begin
            for (i = 0; i < 32; i = i + 1) begin
                if (i == 7) expect_dec(8'ha7, `OP_ADD_IMMEDIATE_STACK_POINTER,
                    `MODE_IMMEDIATE, `LEN_2, `CYC_2);
                else expect_dec({4'ha + {2'h0, i[4:3]}, 1'b0, i[2:0]},
                    `OP_SUBTRACT + {3'h0, i[2:0]}, col_mode[4*i[4:3] +: 4],
                    col_len[3*i[4:3] +: 3], col_cyc[4*i[4:3] +: 4]);
            end
            u_partner.idle;
            $display("t_rm_columns done");
        end
    endtask
    // Signed branches, compare-branch forms, return, and an uncovered opcode
    task t_special;
        begin
            expect_dec(8'h90, `OP_BRANCH_SIGNED_GE, `MODE_RELATIVE, `LEN_2, `CYC_3);
            expect_dec(8'h91, `OP_BRANCH_SIGNED_LT, `MODE_RELATIVE, `LEN_2, `CYC_3);
            expect_dec(8'h93, `OP_BRANCH_SIGNED_LE, `MODE_RELATIVE, `LEN_2, `CYC_3);
            expect_dec(8'h31, `OP_COMPARE_BRANCH_EQUAL, `MODE_DIRECT, `LEN_3, `CYC_5);
            expect_dec(8'h41, `OP_COMPARE_BRANCH_EQUAL_ACC_IMM, `MODE_IMMEDIATE, `LEN_3,
                `CYC_4);
            expect_dec(8'h51, `OP_COMPARE_BRANCH_EQUAL_INDEX_IMM, `MODE_IMMEDIATE, `LEN_3,
                `CYC_4);
            expect_dec(8'h61, `OP_COMPARE_BRANCH_EQUAL, `MODE_INDEXED_8BIT_OFFSET_POSTINC,
                `LEN_3, `CYC_5);
            expect_dec(8'h81, `OP_SUBROUTINE_RETURN, `MODE_INHERENT, `LEN_1, `CYC_4);
            u_partner.send(8'ha8);
            check({5'h00, all_out[23:5]}, {5'h00, 1'b1, 1'b1, 17'h00000});
            u_partner.idle;
            $display("t_special done");
        end
    endtask
    // Prefix pairs: stack forms with the prefix counted
    task t_prefix;
        begin
            u_partner.send(`PREFIX_SP);
            check({22'h0, dec_valid, prefix_pending}, 24'h000001);
            expect_dec(8'he6, `OP_LOAD_ACCUMULATOR, `MODE_STACK_8BIT_OFFSET, `LEN_3,
                `CYC_4);
            check({23'h0, prefix_pending}, 24'h000000);
            u_partner.send(`PREFIX_SP);
            expect_dec(8'h61, `OP_COMPARE_BRANCH_EQUAL, `MODE_STACK_8BIT_OFFSET, `LEN_4,
                `CYC_6);
            u_partner.send(`PREFIX_SP);
            expect_dec(8'hd7, `OP_STORE_ACCUMULATOR, `MODE_STACK_16BIT_OFFSET, `LEN_4,
                `CYC_5);
            u_partner.idle;
            $display("t_prefix done");
        end
    endtask
    // Post-increment compare-branch advances the index once
    task t_index;
        begin
            expect_dec(8'h71, `OP_COMPARE_BRANCH_EQUAL, `MODE_INDEXED_POSTINC, `LEN_2,
                `CYC_4);
            check({23'h0, dec_postinc}, 24'h000001);
            u_partner.idle;
            u_partner.operand_done(16'h0010);
            check({7'h00, index_update, index_next}, 24'h010011);
            u_partner.idle;
            u_partner.operand_done(16'h0020);
            check({23'h0, index_update}, 24'h000000);
            u_partner.idle;
            $display("t_index done");
        end
    endtask

    // Hang guard: whole run needs under a hundred cycles
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            stop_test;
        end
    end

    // Main sequence
    initial begin
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        t_reset;
        t_bit_rows;
        t_rm_columns;
        t_special;
        t_prefix;
        t_index;
        stop_test;
    end
endmodule
